// ==== motor_ss_clock_gating.sv ====
// module: AHB-Lite register block steering sub-unit clock gating and idle policy
// Operation
// - policy 0 acknowledges idle requests at once
// - policy 1 never idles nor acknowledges
// - policy 2 acknowledges when activity allows
// - smart idle raises no wakeup events
// - suspend honoured while ignore bit clear
// - ignore bit set masks debug suspend
// - gate control at 8h, reset 111h
// - bit 9 drives pwm stop request
// - bit 8 drives pwm clock enable
// - bit 5 drives quadrature stop request
// - bit 4 drives quadrature clock enable
// - bit 1 drives capture stop request
// - bit 0 drives capture clock enable
// - idle policy bits 3:2, reset 2
// - stop acks readable at 9,5,1
// - enable status readable at 8,4,0
`timescale 1ns/100ps
`default_nettype none
module motor_ss_clock_gating
  import motor_ss_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic idle_req,
  input wire logic unit_busy,
  output logic idle_ack,
  output logic wakeup,
  input wire logic debug_suspend,
  output logic suspend_out,
  output logic subsystem_reset,
  output logic pwm_unit_stop_request,
  output logic pwm_unit_gate_on,
  output logic quad_unit_stop_request,
  output logic quad_unit_gate_on,
  output logic capture_unit_stop_request,
  output logic capture_unit_gate_on,
  input wire logic pwm_stop_ack,
  input wire logic pwm_gate_status,
  input wire logic quad_stop_ack,
  input wire logic quad_gate_status,
  input wire logic capture_stop_ack,
  input wire logic capture_gate_status
);

  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic [31:0] masked_write(input logic [31:0] data, input logic [31:0] mask);
    masked_write = data & mask;
  endfunction : masked_write

  // ********************************************************************
  // AHB-Lite address phase capture
  // ********************************************************************
  logic wr_pend_reg;
  logic [11:0] addr_reg;
  logic [31:0] clkctl_reg;
  logic [3:0] syscfg_reg;
  logic soft_rst_reg;
  logic [31:0] status_word;
  logic access;

  // only whole-word transfers are decoded; others complete with no effect
  assign access = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= access && hwrite;
      if (access) begin
        addr_reg <= haddr[11:0];
      end
    end
  end

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ********************************************************************
  // clock gate control register
  // ********************************************************************
  // reset to 111h
  always_ff @(posedge clk) begin
    if (rst || soft_rst_reg) begin
      clkctl_reg <= CLKCTL_RESET;
    end else if (wr_pend_reg && addr_reg == CLKCTL_OFF) begin
      clkctl_reg <= masked_write(hwdata, CLKCTL_MASK);
    end
  end

  assign pwm_unit_stop_request = clkctl_reg[PWM_STOP_BIT];
  assign pwm_unit_gate_on = clkctl_reg[PWM_EN_BIT];
  assign quad_unit_stop_request = clkctl_reg[QUAD_STOP_BIT];
  assign quad_unit_gate_on = clkctl_reg[QUAD_EN_BIT];
  assign capture_unit_stop_request = clkctl_reg[CAP_STOP_BIT];
  assign capture_unit_gate_on = clkctl_reg[CAP_EN_BIT];

  // ********************************************************************
  // power configuration register and soft reset
  // ********************************************************************
  always_ff @(posedge clk) begin
    if (rst || soft_rst_reg) begin
      syscfg_reg <= SYSCFG_RESET[3:0];
    end else if (wr_pend_reg && addr_reg == SYSCFG_OFF) begin
      syscfg_reg[IDLE_HI:IDLE_LO] <= hwdata[IDLE_HI:IDLE_LO];
      syscfg_reg[SUSPEND_IGNORE_BIT] <= hwdata[SUSPEND_IGNORE_BIT];
      syscfg_reg[SOFT_RESET_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || soft_rst_reg) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_pend_reg && addr_reg == SYSCFG_OFF && hwdata[SOFT_RESET_BIT];
    end
  end

  assign subsystem_reset = soft_rst_reg;

  // ********************************************************************
  // debug suspend
  // ********************************************************************
  // ignore bit masks suspend
  assign suspend_out = debug_suspend && !syscfg_reg[SUSPEND_IGNORE_BIT];

  // ********************************************************************
  // idle handshake
  // ********************************************************************
  idle_handshake u_idle (
    .clk(clk),
    .rst(rst || soft_rst_reg),
    .policy(syscfg_reg[IDLE_HI:IDLE_LO]),
    .idle_req(idle_req),
    .busy(unit_busy),
    .idle_ack(idle_ack),
    .wakeup(wakeup)
  );

  // ********************************************************************
  // read path
  // ********************************************************************
  // sub-unit status bits
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[PWM_STOP_BIT] = pwm_stop_ack;
    status_word[PWM_EN_BIT] = pwm_gate_status;
    status_word[QUAD_STOP_BIT] = quad_stop_ack;
    status_word[QUAD_EN_BIT] = quad_gate_status;
    status_word[CAP_STOP_BIT] = capture_stop_ack;
    status_word[CAP_EN_BIT] = capture_gate_status;
  end

  // data registered at the address phase so it stands through the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (access && !hwrite) begin
      case (haddr[11:0])
        ID_REG_OFF: begin
          hrdata <= ID_VALUE;
        end
        SYSCFG_OFF: begin
          hrdata <= {28'h0000000, syscfg_reg};
        end
        CLKCTL_OFF: begin
          hrdata <= clkctl_reg;
        end
        CLKSTAT_OFF: begin
          hrdata <= status_word;
        end
        default: begin
          hrdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  a_gate_reset: assert property (@(posedge clk)
    rst |=> clkctl_reg == CLKCTL_RESET)
    else $error("gate control not at reset value");

  a_pwm_stop: assert property (@(posedge clk) disable iff (rst)
    (wr_pend_reg && addr_reg == CLKCTL_OFF && !soft_rst_reg)
      |=> pwm_unit_stop_request == $past(hwdata[PWM_STOP_BIT]))
    else $error("pwm stop request not written");

  a_cap_enable: assert property (@(posedge clk) disable iff (rst)
    (wr_pend_reg && addr_reg == CLKCTL_OFF && !soft_rst_reg)
      |=> capture_unit_gate_on == $past(hwdata[CAP_EN_BIT]))
    else $error("capture enable not written");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (clkctl_reg & ~CLKCTL_MASK) == 32'h0000_0000)
    else $error("reserved gate bits set");

  a_suspend_mask: assert property (@(posedge clk) disable iff (rst)
    syscfg_reg[SUSPEND_IGNORE_BIT] |-> !suspend_out)
    else $error("suspend passed while ignored");

  a_soft_clear: assert property (@(posedge clk) disable iff (rst)
    soft_rst_reg |=> !soft_rst_reg && clkctl_reg == CLKCTL_RESET
      && syscfg_reg == SYSCFG_RESET[3:0])
    else $error("soft reset did not restore state");

  a_status_read: assert property (@(posedge clk) disable iff (rst)
    (access && !hwrite && haddr[11:0] == CLKSTAT_OFF)
      |=> hrdata[PWM_STOP_BIT] == $past(pwm_stop_ack))
    else $error("status read mismatch");

  a_policy_reset: assert property (@(posedge clk)
    rst |=> syscfg_reg[IDLE_HI:IDLE_LO] == IDLE_SMART)
    else $error("idle policy not smart after reset");

  a_pwm_enable: assert property (@(posedge clk) disable iff (rst)
    (wr_pend_reg && addr_reg == CLKCTL_OFF && !soft_rst_reg)
      |=> pwm_unit_gate_on == $past(hwdata[PWM_EN_BIT]))
    else $error("pwm enable not written");

  a_quad_stop: assert property (@(posedge clk) disable iff (rst)
    (wr_pend_reg && addr_reg == CLKCTL_OFF && !soft_rst_reg)
      |=> quad_unit_stop_request == $past(hwdata[QUAD_STOP_BIT]))
    else $error("quadrature stop request not written");

  a_quad_enable: assert property (@(posedge clk) disable iff (rst)
    (wr_pend_reg && addr_reg == CLKCTL_OFF && !soft_rst_reg)
      |=> quad_unit_gate_on == $past(hwdata[QUAD_EN_BIT]))
    else $error("quadrature enable not written");

  a_cap_stop: assert property (@(posedge clk) disable iff (rst)
    (wr_pend_reg && addr_reg == CLKCTL_OFF && !soft_rst_reg)
      |=> capture_unit_stop_request == $past(hwdata[CAP_STOP_BIT]))
    else $error("capture stop request not written");

  a_enable_read: assert property (@(posedge clk) disable iff (rst)
    (access && !hwrite && haddr[11:0] == CLKSTAT_OFF)
      |=> hrdata[QUAD_EN_BIT] == $past(quad_gate_status))
    else $error("enable status read mismatch");

  a_pwm_en_read: assert property (@(posedge clk) disable iff (rst)
    (access && !hwrite && haddr[11:0] == CLKSTAT_OFF)
      |=> hrdata[PWM_EN_BIT] == $past(pwm_gate_status))
    else $error("pwm enable status read mismatch");

  a_cap_ack_read: assert property (@(posedge clk) disable iff (rst)
    (access && !hwrite && haddr[11:0] == CLKSTAT_OFF)
      |=> hrdata[CAP_STOP_BIT] == $past(capture_stop_ack))
    else $error("capture stop ack read mismatch");

  a_suspend_pass: assert property (@(posedge clk) disable iff (rst)
    debug_suspend && !syscfg_reg[SUSPEND_IGNORE_BIT] |-> suspend_out)
    else $error("suspend not passed while honoured");

  // a gate pin that moves without a write would stop a running sub-unit
  a_gate_hold: assert property (@(posedge clk) disable iff (rst)
    !(wr_pend_reg && addr_reg == CLKCTL_OFF) && !soft_rst_reg |=> $stable(clkctl_reg))
    else $error("gate control changed without a write");

  a_power_read: assert property (@(posedge clk) disable iff (rst)
    (access && !hwrite && haddr[11:0] == SYSCFG_OFF)
      |=> (hrdata & ~SYSCFG_MASK) == 32'h0000_0000 && !hrdata[SOFT_RESET_BIT])
    else $error("power config read shows reserved bits");

  // ********************************************************************
  // soft reset steps
  // ********************************************************************
  // the write triggers it; the pulse must last exactly one cycle
  sequence soft_write_seen;
    wr_pend_reg && addr_reg == SYSCFG_OFF && hwdata[SOFT_RESET_BIT] && !soft_rst_reg;
  endsequence

  sequence soft_pulse_once;
    soft_rst_reg ##1 !soft_rst_reg;
  endsequence

  a_soft_pulse: assert property (@(posedge clk) disable iff (rst)
    soft_write_seen |=> soft_pulse_once)
    else $error("soft reset pulse not single");

endmodule : motor_ss_clock_gating
`default_nettype wire

// ==== motor_ss_pkg.sv ====
// package: register map, field positions and codes for the motor subsystem clock gating block
package motor_ss_pkg;

  // ********************************************************************
  // register byte offsets
  // ********************************************************************
  localparam logic [11:0] ID_REG_OFF = 12'h000;
  localparam logic [11:0] SYSCFG_OFF = 12'h004;
  localparam logic [11:0] CLKCTL_OFF = 12'h008;
  localparam logic [11:0] CLKSTAT_OFF = 12'h00C;

  // ********************************************************************
  // field positions and reset values
  // ********************************************************************
  localparam int SOFT_RESET_BIT = 0;
  localparam int SUSPEND_IGNORE_BIT = 1;
  localparam int IDLE_LO = 2;
  localparam int IDLE_HI = 3;
  localparam int CAP_EN_BIT = 0;
  localparam int CAP_STOP_BIT = 1;
  localparam int QUAD_EN_BIT = 4;
  localparam int QUAD_STOP_BIT = 5;
  localparam int PWM_EN_BIT = 8;
  localparam int PWM_STOP_BIT = 9;
  localparam logic [31:0] CLKCTL_MASK = 32'h0000_0333;
  localparam logic [31:0] CLKCTL_RESET = 32'h0000_0111;
  localparam logic [31:0] SYSCFG_MASK = 32'h0000_000F;
  localparam logic [31:0] SYSCFG_RESET = 32'h0000_0008;
  // identification word: value is arbitrary
  localparam logic [31:0] ID_VALUE = 32'h0000_0A17;

  // ********************************************************************
  // idle policy and bus codes
  // ********************************************************************
  typedef enum logic [1:0] {
    IDLE_FORCE = 2'h0,
    IDLE_NEVER = 2'h1,
    IDLE_SMART = 2'h2,
    IDLE_RSVD = 2'h3
  } idle_policy_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage : motor_ss_pkg

// ==== idle_handshake.sv ====
// module: target idle handshake under the selected idle policy
`timescale 1ns/100ps
`default_nettype none
module idle_handshake
  import motor_ss_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] policy,
  input wire logic idle_req,
  input wire logic busy,
  output logic idle_ack,
  output logic wakeup
);

  // ********************************************************************
  // ack state machine
  // ********************************************************************
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_IDLE = 2'b01
  } idle_state_t;

  idle_state_t state_reg;
  idle_state_t state_next;

  always_comb begin
    state_next = state_reg;
    case (policy)
      IDLE_FORCE: begin
        state_next = idle_req ? ST_IDLE : ST_ACTIVE;
      end
      IDLE_NEVER: begin
        state_next = ST_ACTIVE;
      end
      IDLE_SMART: begin
        state_next = (idle_req && !busy) ? ST_IDLE : ST_ACTIVE;
      end
      // reserved code behaves as never idle, the safe choice
      default: begin
        state_next = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign idle_ack = (state_reg == ST_IDLE);

  assign wakeup = busy && idle_ack && (policy != IDLE_SMART);

  // ********************************************************************
  // checks
  // ********************************************************************
  a_never_ack: assert property (@(posedge clk) disable iff (rst)
    $past(policy) == IDLE_NEVER |-> !idle_ack)
    else $error("ack under never-idle policy");

  a_force_ack: assert property (@(posedge clk) disable iff (rst)
    (policy == IDLE_FORCE && idle_req) |=> idle_ack || $past(policy) != IDLE_FORCE)
    else $error("force idle not acknowledged");

  a_smart_busy: assert property (@(posedge clk) disable iff (rst)
    (policy == IDLE_SMART && busy) |=> !idle_ack)
    else $error("smart idle ack while busy");

  a_smart_wake: assert property (@(posedge clk) disable iff (rst)
    policy == IDLE_SMART |-> !wakeup)
    else $error("wakeup under smart idle");

endmodule : idle_handshake
`default_nettype wire

// ==== motor_unit_model.sv ====
// sub-unit clock management model: acks follow requests after a latency
`timescale 1ns/100ps
`default_nettype none
module motor_unit_model #(
  parameter int LAT = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic gate_on,
  input wire logic stop_request,
  output logic stop_ack,
  output logic gate_status
);
  // ****************************************************************
  // ack pipelines
  // ****************************************************************
  // a slow unit shows the old status for LAT cycles, so stale reads are caught
  logic [LAT:0] on_reg;
  logic [LAT:0] stop_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      on_reg <= '0;
      stop_reg <= '0;
    end else begin
      on_reg <= {on_reg[LAT-1:0], gate_on};
      stop_reg <= {stop_reg[LAT-1:0], stop_request};
    end
  end
  assign gate_status = on_reg[LAT-1];
  assign stop_ack = stop_reg[LAT-1];
endmodule : motor_unit_model
`default_nettype wire

// ==== test_motor_subsystem_clock_gating.sv ====
// testbench: register access, gating pins, status, idle, suspend, soft reset
`timescale 1ns/100ps
`default_nettype none
module test_motor_subsystem_clock_gating;
  import motor_ss_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic idle_req = 1'b0, unit_busy = 1'b0, debug_suspend = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic hreadyout, hresp, idle_ack, wakeup, suspend_out, subsystem_reset;
  logic p_stop, p_on, q_stop, q_on, c_stop, c_on, p_ack, p_st, q_ack, q_st, c_ack, c_st;
  logic [5:0] pins;
  int fails = 0, checks = 0, seen;
  logic [3:0] exp_busy = 4'b0001, exp_free = 4'b0101;
  typedef struct packed {logic [31:0] w; logic [31:0] rd; logic [5:0] pins;} row_t;
  row_t rows [6] = '{'{32'h0000_0000, 32'h0000_0000, 6'h00},
    '{32'hFFFF_FFFF, 32'h0000_0333, 6'h3F}, '{32'h0000_0200, 32'h0000_0200, 6'h20},
    '{32'h0000_0010, 32'h0000_0010, 6'h04}, '{32'h0000_0002, 32'h0000_0002, 6'h02},
    '{32'hFFFF_FCCD, 32'h0000_0001, 6'h01}};
  assign pins = {p_stop, p_on, q_stop, q_on, c_stop, c_on};
  always #25 clk = ~clk;
  motor_ss_clock_gating dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .idle_req(idle_req),
    .unit_busy(unit_busy), .idle_ack(idle_ack), .wakeup(wakeup),
    .debug_suspend(debug_suspend), .suspend_out(suspend_out),
    .subsystem_reset(subsystem_reset), .pwm_unit_stop_request(p_stop),
    .pwm_unit_gate_on(p_on), .quad_unit_stop_request(q_stop), .quad_unit_gate_on(q_on),
    .capture_unit_stop_request(c_stop), .capture_unit_gate_on(c_on),
    .pwm_stop_ack(p_ack), .pwm_gate_status(p_st), .quad_stop_ack(q_ack),
    .quad_gate_status(q_st), .capture_stop_ack(c_ack), .capture_gate_status(c_st));
  motor_unit_model #(.LAT(1)) m_pwm (.clk(clk), .rst(rst), .gate_on(p_on),
    .stop_request(p_stop), .stop_ack(p_ack), .gate_status(p_st));
  motor_unit_model #(.LAT(3)) m_quad (.clk(clk), .rst(rst), .gate_on(q_on),
    .stop_request(q_stop), .stop_ack(q_ack), .gate_status(q_st));
  motor_unit_model #(.LAT(6)) m_cap (.clk(clk), .rst(rst), .gate_on(c_on),
    .stop_request(c_stop), .stop_ack(c_ack), .gate_status(c_st));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fails++;
      final_report;
    end
  endtask : wait_ready
  // one single word transfer; read data taken at the data phase edge
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    q = hrdata;
    chk(32'(hresp), 32'h0);
  endtask : bus
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk(32'(pins), 32'h15);
    bus(1'b0, CLKCTL_OFF, 32'h0, rd);
    chk(rd, 32'h0000_0111);
    bus(1'b0, SYSCFG_OFF, 32'h0, rd);
    chk(rd, 32'h0000_0008);
    bus(1'b0, 12'h010, 32'h0, rd);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, CLKCTL_OFF, rows[i].w, rd);
      #1 chk(32'(pins), 32'(rows[i].pins));
      bus(1'b0, CLKCTL_OFF, 32'h0, rd);
      chk(rd, rows[i].rd);
      repeat (8) @(posedge clk);
      bus(1'b0, CLKSTAT_OFF, 32'h0, rd);
      chk(rd, rows[i].rd);
    end
    bus(1'b1, SYSCFG_OFF, 32'hFFFF_FFF6, rd);
    bus(1'b0, SYSCFG_OFF, 32'h0, rd);
    chk(rd, 32'h0000_0006);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, SYSCFG_OFF, {28'h0, p[1:0], 2'b00}, rd);
      idle_req <= 1'b1;
      unit_busy <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(32'(idle_ack), 32'(exp_busy[p]));
      @(posedge clk);
      unit_busy <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(32'(idle_ack), 32'(exp_free[p]));
      @(posedge clk);
      unit_busy <= 1'b1;
      #1 chk(32'(wakeup), 32'(exp_busy[p]));
      @(posedge clk);
      idle_req <= 1'b0;
      unit_busy <= 1'b0;
    end
    for (int g = 0; g < 2; g++) begin
      bus(1'b1, SYSCFG_OFF, {28'h0, 2'b10, g[0], 1'b0}, rd);
      debug_suspend <= 1'b1;
      @(posedge clk);
      #1 chk(32'(suspend_out), 32'(g == 0));
      @(posedge clk);
      debug_suspend <= 1'b0;
    end
    bus(1'b1, CLKCTL_OFF, 32'h0, rd);
    bus(1'b1, SYSCFG_OFF, 32'h0000_0007, rd);
    seen = 0;
    repeat (4) begin
      #1 if (subsystem_reset === 1'b1) seen++;
      @(posedge clk);
    end
    chk(32'(seen), 32'h1);
    bus(1'b0, CLKCTL_OFF, 32'h0, rd);
    chk(rd, 32'h0000_0111);
    bus(1'b0, SYSCFG_OFF, 32'h0, rd);
    chk(rd, 32'h0000_0008);
    // reset again in mid-run with non-default settings in place
    bus(1'b1, CLKCTL_OFF, 32'h0000_0222, rd);
    bus(1'b1, SYSCFG_OFF, 32'h0000_0006, rd);
    #1 chk(32'(pins), 32'h2A);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk(32'(pins), 32'h15);
    bus(1'b0, SYSCFG_OFF, 32'h0, rd);
    chk(rd, 32'h0000_0008);
    final_report;
  end
endmodule : test_motor_subsystem_clock_gating
`default_nettype wire
